// ---- verilog/flash_command_controller.sv ----
// Our own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module flash_command_controller
	import flash_ctrl_pkg::*;
#(
	parameter int EXEC_COUNT = EXEC_CYCLES
) (
	input  wire logic            i_clk,
	input  wire logic            i_sys_rst,
	input  wire logic            i_wb_cyc,
	input  wire logic            i_wb_stb,
	input  wire logic            i_wb_we,
	input  wire logic [3:0]      i_wb_sel,
	input  wire logic [ADDR_W+1:0] i_wb_adr,
	input  wire logic [31:0]     i_wb_dat,
	input  wire logic [7:0]      i_nv_protect,
	input  wire logic [7:0]      i_nv_security,
	output logic [31:0]          o_wb_dat,
	output logic                 o_wb_ack,
	output logic                 o_cpu_hold,
	output logic                 o_irq_buffer_empty,
	output logic                 o_irq_complete,
	output logic                 o_exec_busy
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	wb_req_t     req;
	exec_req_t   exec;
	seq_state_t  seq;
	logic        loader_busy;
	logic [7:0]  protect_setting_reg;
	logic [7:0]  security_setting_reg;
	logic [7:0]  nv_prot_loaded;
	logic [7:0]  nv_sec_loaded;
	logic        timer_busy;
	logic        timer_done;
	logic        timer_abort;
	logic [7:0]  clock_divider_reg;
	logic        divider_set;
	logic [7:0]  configuration_reg;
	logic [7:0]  mode_reg;
	logic [7:0]  command_reg;
	logic [15:0] word_addr;
	logic [15:0] word_data;
	logic        buffer_empty_flag;
	logic        command_complete_flag;
	logic        access_error_flag;
	logic        protection_violation_flag;
	logic        fail_flag;
	logic        done_flag;
	logic        blank_flag;
	logic        pending;
	logic [7:0]  idx;
	logic        wr;
	logic        rd;
	logic [7:0]  wbyte;
	logic        byte_only;
	logic        special;
	logic        stop_req;
	logic        secured;
	logic        next_aerr;
	logic        next_protection_violation_flag;
	logic        abort;
	logic        launch;
	logic        cmd_valid;
	logic [2:0]  scen_cur;
	logic [2:0]  scen_new;
	logic        scen_ok;
	logic        addr_protected;

	assign req = '{cyc: i_wb_cyc, stb: i_wb_stb, we: i_wb_we, sel: i_wb_sel, adr: i_wb_adr, dat: i_wb_dat};

	// ----------------------------------------
	// Sub-blocks
	// ----------------------------------------
	flash_reset_loader u_loader (
		.i_clk         (i_clk),
		.i_sys_rst     (i_sys_rst),
		.i_nv_protect  (i_nv_protect),
		.i_nv_security (i_nv_security),
		.o_busy        (loader_busy),
		.o_protect     (nv_prot_loaded),
		.o_security    (nv_sec_loaded)
	);

	flash_exec_timer #(.EXEC_COUNT(EXEC_COUNT)) u_timer (
		.i_clk     (i_clk),
		.i_sys_rst (i_sys_rst),
		.i_start   (exec.launch),
		.i_abort   (timer_abort),
		.o_busy    (timer_busy),
		.o_done    (timer_done)
	);

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	// Registers other than IDX_ARRAY_ADDR are byte wide, so only lane 0 counts as their data
	assign idx       = i_wb_adr[ADDR_W+1:2];
	assign wr        = req.cyc && req.stb && req.we && !o_wb_ack && !loader_busy;
	assign rd        = req.cyc && req.stb && !req.we && !o_wb_ack;
	assign wbyte     = req.dat[7:0];
	assign byte_only = (req.sel != 4'h3);
	assign special   = mode_reg[BIT_SPECIAL];
	assign stop_req  = mode_reg[BIT_STOP];
	assign secured   = (security_setting_reg[1:0] != SEC_OPEN_KEY);
	assign scen_cur  = protect_setting_reg[2:0];
	assign scen_new  = wbyte[2:0];

	// Command codes understood by the controller
	always_comb begin
		unique case (wbyte)
			CMD_BLANK, CMD_PROGRAM, CMD_SECTOR, CMD_MASS: cmd_valid = 1'b1;
			default:                                     cmd_valid = 1'b0;
		endcase
	end

	// Scenario 6 reaches only 1, 3, 4 and 6; scenario 7 reaches all
	always_comb begin
		scen_ok = 1'b0;
		if (scen_cur == SCEN_FULL)
			scen_ok = 1'b1;
		else if (scen_cur == SCEN_LIMITED)
			scen_ok = (scen_new == 3'h1) || (scen_new == 3'h3) || (scen_new == 3'h4) || (scen_new == 3'h6);
		else
			scen_ok = (scen_new == scen_cur);
	end

	// Upper half of array is protected when protection bit 7 clear
	assign addr_protected = !protect_setting_reg[7] && word_addr[15];

	// ----------------------------------------
	// Sequence error detection
	// ----------------------------------------
	always_comb begin
		next_aerr  = 1'b0;
		next_protection_violation_flag = 1'b0;
		launch     = 1'b0;
		if (stop_req && (timer_busy || pending))
			next_aerr = 1'b1;
		if (wr) begin
			if (idx == IDX_ARRAY_ADDR) begin
				if (!divider_set || byte_only || req.dat[16])
					next_aerr = 1'b1;
				else if (!buffer_empty_flag || seq != SEQ_IDLE)
					next_aerr = 1'b1;
			end else if (seq == SEQ_WORD) begin
				if (idx != IDX_COMMAND)
					next_aerr = 1'b1;
				else if (!cmd_valid)
					next_aerr = 1'b1;
				else if (secured && mode_reg[BIT_NONSEC] && wbyte != CMD_MASS)
					next_aerr = 1'b1;
				else if (wbyte == CMD_MASS && protect_setting_reg != PROT_NONE)
					next_protection_violation_flag = 1'b1;
				else if (wbyte != CMD_MASS && addr_protected)
					next_protection_violation_flag = 1'b1;
			end else if (seq == SEQ_CMD) begin
				if (idx == IDX_COMMAND)
					next_aerr = 1'b1;
				else if (idx != IDX_STATUS)
					next_aerr = 1'b1;
				else if (!wbyte[BIT_BEF])
					next_aerr = 1'b1;
				else if (!access_error_flag && !protection_violation_flag)
					launch = 1'b1;
			end
		end
	end

	assign abort       = next_aerr || next_protection_violation_flag;
	assign timer_abort = stop_req && timer_busy;
	assign exec        = '{launch: launch, cmd: command_reg, addr: word_addr};

	// ----------------------------------------
	// Command write sequence
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			seq         <= SEQ_IDLE;
			word_addr   <= 16'h0000;
			word_data   <= 16'h0000;
			command_reg <= 8'h00;
			pending     <= 1'b0;
		end else begin
			if (abort) begin
				seq     <= SEQ_IDLE;
				pending <= 1'b0;
			end else if (launch || (wr && seq == SEQ_CMD)) begin
				seq     <= SEQ_IDLE; // A locked launch still closes the sequence
				pending <= launch && timer_busy;
			end else if (wr && idx == IDX_ARRAY_ADDR) begin
				seq       <= SEQ_WORD;
				word_addr <= req.dat[31:16];
				word_data <= req.dat[15:0];
			end else if (wr && seq == SEQ_WORD) begin
				seq         <= SEQ_CMD;
				command_reg <= wbyte;
			end
			if (timer_done && pending)
				pending <= 1'b0;
		end
	end

	// ----------------------------------------
	// Status flags
	// ----------------------------------------
	// Hardware sets win over software clears in the same cycle
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			buffer_empty_flag         <= 1'b1;
			command_complete_flag     <= 1'b1;
			access_error_flag         <= 1'b0;
			protection_violation_flag <= 1'b0;
			fail_flag                 <= 1'b0;
			done_flag                 <= 1'b0;
			blank_flag                <= 1'b0;
		end else begin
			if (wr && idx == IDX_STATUS) begin
				if (wbyte[BIT_AEF])
					access_error_flag <= 1'b0;
				if (wbyte[BIT_PVF])
					protection_violation_flag <= 1'b0;
				if (special)
					fail_flag <= wbyte[BIT_FAIL];
			end
			if (next_aerr)
				access_error_flag <= 1'b1;
			if (next_protection_violation_flag)
				protection_violation_flag <= 1'b1;
			if (launch) begin
				buffer_empty_flag     <= pending || !timer_busy ? 1'b0 : 1'b1;
				command_complete_flag <= 1'b0;
			end else if (timer_done) begin
				buffer_empty_flag <= 1'b1;
				if (!pending)
					command_complete_flag <= 1'b1;
				done_flag  <= 1'b1;
				blank_flag <= (command_reg == CMD_BLANK);
			end else if ((abort && !timer_busy) || timer_abort) begin // Running command outlives a bad sequence
				buffer_empty_flag     <= 1'b1;
				command_complete_flag <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			clock_divider_reg    <= 8'h00;
			divider_set          <= 1'b0;
			configuration_reg    <= 8'h00;
			mode_reg             <= 8'h00;
			protect_setting_reg  <= PROT_NONE;
			security_setting_reg <= 8'h00;
		end else begin
			if (loader_busy) begin
				protect_setting_reg  <= nv_prot_loaded;
				security_setting_reg <= nv_sec_loaded;
			end else if (wr && seq == SEQ_IDLE) begin
				unique case (idx)
					IDX_CLKDIV: begin
						if (!divider_set) begin
							clock_divider_reg <= wbyte;
							divider_set       <= 1'b1;
						end
					end
					IDX_CONFIG:  configuration_reg <= wbyte;
					IDX_MODE:    mode_reg          <= wbyte;
					IDX_PROTECT: begin
						if (scen_ok)
							protect_setting_reg <= {wbyte[7:3], scen_new};
					end
					default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// Bus answer and outputs
	// ----------------------------------------
	// One-cycle ack; unmapped reads return zero
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_wb_ack <= 1'b0;
			o_wb_dat <= 32'h0;
		end else begin
			o_wb_ack <= req.cyc && req.stb && !o_wb_ack && !loader_busy;
			if (rd) begin
				unique case (idx)
					IDX_CLKDIV:   o_wb_dat <= {24'h0, clock_divider_reg};
					IDX_SECURITY: o_wb_dat <= {24'h0, security_setting_reg};
					IDX_CONFIG:   o_wb_dat <= {24'h0, configuration_reg};
					IDX_PROTECT:  o_wb_dat <= {24'h0, protect_setting_reg};
					IDX_STATUS:   o_wb_dat <= {24'h0, buffer_empty_flag, command_complete_flag,
						protection_violation_flag, access_error_flag, 1'b0, blank_flag,
						special & fail_flag, special & done_flag};
					IDX_COMMAND:  o_wb_dat <= {24'h0, command_reg};
					IDX_MODE:     o_wb_dat <= {24'h0, mode_reg};
					IDX_ARRAY_ADDR: o_wb_dat <= command_complete_flag ? {word_addr, word_data} : 32'h0;
					default:      o_wb_dat <= 32'h0;
				endcase
			end
		end
	end

	// Interrupt requests and status outputs registered
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_irq_buffer_empty <= 1'b0;
			o_irq_complete     <= 1'b0;
			o_cpu_hold         <= 1'b1;
			o_exec_busy        <= 1'b0;
		end else begin
			o_irq_buffer_empty <= buffer_empty_flag && configuration_reg[BIT_BE_IE];
			o_irq_complete     <= command_complete_flag && configuration_reg[BIT_CC_IE];
			o_cpu_hold         <= loader_busy;
			o_exec_busy        <= timer_busy;
		end
	end
endmodule // flash_command_controller

// ---- verilog/flash_ctrl_pkg.sv ----
package flash_ctrl_pkg;

	// ----------------------------------------
	// Register map (byte-wide registers except the 32-bit IDX_ARRAY_ADDR, one aligned word each)
	// ----------------------------------------
	localparam int         ADDR_W          = 8;
	localparam logic [7:0] IDX_CLKDIV      = 8'h00;
	localparam logic [7:0] IDX_SECURITY    = 8'h01;
	localparam logic [7:0] IDX_CONFIG      = 8'h03;
	localparam logic [7:0] IDX_PROTECT     = 8'h04;
	localparam logic [7:0] IDX_STATUS      = 8'h05;
	localparam logic [7:0] IDX_COMMAND     = 8'h06;
	localparam logic [7:0] IDX_ARRAY_ADDR  = 8'h08;
	localparam logic [7:0] IDX_ARRAY_DATA  = 8'h09;
	localparam logic [7:0] IDX_MODE        = 8'h0A;

	// ----------------------------------------
	// Status bit positions
	// ----------------------------------------
	localparam int BIT_BEF   = 7;
	localparam int BIT_CCF   = 6;
	localparam int BIT_PVF   = 5;
	localparam int BIT_AEF   = 4;
	localparam int BIT_BLANK = 2;
	localparam int BIT_FAIL  = 1;
	localparam int BIT_DONE  = 0;

	// Configuration bit positions
	localparam int BIT_BE_IE = 7;
	localparam int BIT_CC_IE = 6;

	// Mode register bit positions
	localparam int BIT_SPECIAL = 0;
	localparam int BIT_STOP    = 1;
	localparam int BIT_NONSEC  = 2;

	// Security: enabled unless this key is loaded
	localparam logic [1:0] SEC_OPEN_KEY = 2'h2;
	localparam logic [7:0] PROT_NONE    = 8'hFF;

	// ----------------------------------------
	// Command codes
	// ----------------------------------------
	localparam logic [7:0] CMD_BLANK   = 8'h05;
	localparam logic [7:0] CMD_PROGRAM = 8'h20;
	localparam logic [7:0] CMD_SECTOR  = 8'h40;
	localparam logic [7:0] CMD_MASS    = 8'h41;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int         CLK_MHZ      = 100;
	localparam int         EXEC_TIME_US = 20;
	localparam int         EXEC_CYCLES  = EXEC_TIME_US * CLK_MHZ;
	localparam int         LOAD_CYCLES  = 4;
	localparam logic [2:0] SCEN_FULL    = 3'h7;
	localparam logic [2:0] SCEN_LIMITED = 3'h6;

	typedef enum {SEQ_IDLE, SEQ_WORD, SEQ_CMD} seq_state_t;

	typedef struct packed {
		logic                  cyc;
		logic                  stb;
		logic                  we;
		logic [3:0]            sel;
		logic [ADDR_W+1:0]     adr;
		logic [31:0]           dat;
	} wb_req_t;

	typedef struct packed {
		logic       launch;
		logic [7:0] cmd;
		logic [15:0] addr;
	} exec_req_t;

endpackage

// ---- verilog/flash_reset_loader.sv ----
`timescale 1ns/1ps
module flash_reset_loader
	import flash_ctrl_pkg::*;
(
	input  wire logic       i_clk,
	input  wire logic       i_sys_rst,
	input  wire logic [7:0] i_nv_protect,
	input  wire logic [7:0] i_nv_security,
	output logic            o_busy,
	output logic [7:0]      o_protect,
	output logic [7:0]      o_security
);
	logic [2:0] count;

	// ----------------------------------------
	// Reset-time load
	// ----------------------------------------
	// Busy holds the CPU off until the settings are captured
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count  <= 3'h0;
			o_busy <= 1'b1;
		end else if (o_busy) begin
			count <= count + 3'h1;
			if (count == 3'(LOAD_CYCLES - 1))
				o_busy <= 1'b0;
		end
	end

	// Values taken after release, never inside the reset branch
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_protect  <= PROT_NONE;
			o_security <= 8'h00;
		end else if (o_busy) begin // Tracked all load long so the copy at its end is current
			o_protect  <= i_nv_protect;
			o_security <= i_nv_security;
		end
	end
endmodule // flash_reset_loader

// ---- verilog/flash_exec_timer.sv ----
`timescale 1ns/1ps
module flash_exec_timer
	import flash_ctrl_pkg::*;
#(
	parameter int EXEC_COUNT = EXEC_CYCLES
) (
	input  wire logic i_clk,
	input  wire logic i_sys_rst,
	input  wire logic i_start,
	input  wire logic i_abort,
	output logic      o_busy,
	output logic      o_done
);
	logic [31:0] count;

	// ----------------------------------------
	// Array operation timer
	// ----------------------------------------
	// Abort clears at once; array contents then undefined
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			count  <= 32'h0;
			o_busy <= 1'b0;
			o_done <= 1'b0;
		end else begin
			o_done <= 1'b0;
			if (i_abort) begin
				o_busy <= 1'b0;
			end else if (i_start && !o_busy) begin
				o_busy <= 1'b1;
				count  <= 32'(EXEC_COUNT - 1);
			end else if (o_busy) begin
				if (count == 32'h0) begin
					o_busy <= 1'b0;
					o_done <= 1'b1;
				end else begin
					count <= count - 32'h1;
				end
			end
		end
	end
endmodule // flash_exec_timer

// ---- verif/flash_cmd_checker_sva.sv ----
`timescale 1ns/1ps
module flash_cmd_checker
	import flash_ctrl_pkg::*;
#(
	parameter int EXEC_COUNT = EXEC_CYCLES
) (
	input wire logic              i_clk,
	input wire logic              i_sys_rst,
	input wire logic              i_wb_cyc,
	input wire logic              i_wb_stb,
	input wire logic              i_wb_we,
	input wire logic [ADDR_W+1:0] i_wb_adr,
	input wire logic [31:0]       i_wb_dat,
	input wire logic [31:0]       o_wb_dat,
	input wire logic              o_wb_ack,
	input wire logic              o_cpu_hold,
	input wire logic              o_irq_buffer_empty,
	input wire logic              o_irq_complete,
	input wire logic              o_exec_busy
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [15:0] busy_cnt;
	logic [2:0]  load_cnt;
	logic [2:0]  launch_age;
	logic        launch_req;

	// Launch request seen on the bus, acked or not
	assign launch_req = i_wb_cyc && i_wb_stb && i_wb_we && i_wb_adr[9:2] == IDX_STATUS && i_wb_dat[BIT_BEF];

	// Cycles spent busy so far
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) busy_cnt <= 16'h0;
		else busy_cnt <= o_exec_busy ? busy_cnt + 16'h1 : 16'h0;
	end

	// Cycles since reset release, saturating
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) load_cnt <= 3'h0;
		else if (load_cnt != 3'h7) load_cnt <= load_cnt + 3'h1;
	end

	// Age of the last launch request, saturating
	always_ff @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) launch_age <= 3'h7;
		else if (launch_req) launch_age <= 3'h0;
		else if (launch_age != 3'h7) launch_age <= launch_age + 3'h1;
	end

	sequence s_ack_pulse;
		o_wb_ack ##1 !o_wb_ack;
	endsequence

	sequence s_busy_settled;
		o_exec_busy && busy_cnt > 16'h1;
	endsequence

	AST_LOAD_HOLD: assert property (load_cnt < LOAD_CYCLES - 1 |-> o_cpu_hold)
		else $error("cpu hold dropped during settings load");
	AST_HOLD_NO_ACK: assert property (o_cpu_hold |-> !o_wb_ack)
		else $error("bus acked while cpu held");
	AST_RST_CLEAN: assert property ($past(i_sys_rst) |-> !o_exec_busy && o_cpu_hold)
		else $error("operation survived reset");
	AST_ACK_TIMING: assert property ($rose(i_wb_cyc && i_wb_stb) && !o_cpu_hold |=> s_ack_pulse)
		else $error("ack not a single pulse one cycle after request");
	AST_ACK_CAUSE: assert property (o_wb_ack |-> i_wb_cyc && i_wb_stb)
		else $error("ack without request");
	AST_RDAT_HOLD: assert property ($changed(o_wb_dat) |-> o_wb_ack && !i_wb_we)
		else $error("read data changed outside a read");
	AST_BUSY_CAUSE: assert property ($rose(o_exec_busy) |-> launch_age < 3'h4)
		else $error("operation started without launch");
	AST_BUSY_IRQ: assert property (s_busy_settled |-> !o_irq_complete && !o_irq_buffer_empty)
		else $error("interrupt while operation runs");
	AST_BUSY_LEN: assert property (o_exec_busy |-> busy_cnt < EXEC_COUNT)
		else $error("operation ran too long");
endmodule // flash_cmd_checker

bind flash_command_controller flash_cmd_checker #(.EXEC_COUNT(EXEC_COUNT)) i_flash_cmd_checker (
	.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we),
	.i_wb_adr(i_wb_adr), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_cpu_hold(o_cpu_hold),
	.o_irq_buffer_empty(o_irq_buffer_empty), .o_irq_complete(o_irq_complete), .o_exec_busy(o_exec_busy));

// ---- verif/cpu_bus_model.sv ----
`timescale 1ns/1ps
module cpu_bus_model
	import flash_ctrl_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_ack,
	input  wire logic [31:0] i_rdat,
	output wb_req_t          o_req,
	output logic             o_timeout
);
	initial begin
		o_req = '0;
		o_timeout = 1'b0;
	end

	// One classic cycle; request held until ack is sampled
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [3:0] s, input logic [31:0] d,
			output logic [31:0] q);
		int n;
		n = 0;
		@(posedge i_clk);
		o_req <= '{cyc:1'b1, stb:1'b1, we:w, sel:s, adr:{idx, 2'h0}, dat:d};
		do begin
			@(posedge i_clk);
			n++;
		end while (i_ack !== 1'b1 && n < 200);
		q = i_rdat;
		if (i_ack !== 1'b1) o_timeout <= 1'b1;
		// Released address and data show the inverse, never a stale copy
		o_req <= '{cyc:1'b0, stb:1'b0, we:1'b0, sel:4'h0, adr:~{idx, 2'h0}, dat:~d};
	endtask
endmodule // cpu_bus_model

// ---- verif/tb_flash_command_controller.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module tb_flash_command_controller;
	import flash_ctrl_pkg::*;
	localparam int EXEC_N = 40;
	logic        i_clk, i_sys_rst, ack, hold, irq_be, irq_cc, busy, tmo;
	logic [7:0]  nv_prot, nv_sec;
	logic [31:0] rdat, q;
	wb_req_t     req;
	int          n_errors, checks, i, n;
	logic [7:0]  cmds [4] = '{CMD_BLANK, CMD_PROGRAM, CMD_SECTOR, CMD_MASS};
	logic [7:0]  pw [3] = '{8'h7F, 8'h79, 8'h7E};
	logic [2:0]  pe [3] = '{3'h6, 3'h1, 3'h1};

	always #5 i_clk = ~i_clk;

	flash_command_controller #(.EXEC_COUNT(EXEC_N)) i_flash_command_controller (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_wb_cyc(req.cyc), .i_wb_stb(req.stb), .i_wb_we(req.we), .i_wb_sel(req.sel), .i_wb_adr(req.adr),
		.i_wb_dat(req.dat), .i_nv_protect(nv_prot), .i_nv_security(nv_sec), .o_wb_dat(rdat), .o_wb_ack(ack),
		.o_cpu_hold(hold), .o_irq_buffer_empty(irq_be), .o_irq_complete(irq_cc), .o_exec_busy(busy));
	cpu_bus_model i_cpu_bus_model (.i_clk(i_clk), .i_ack(ack), .i_rdat(rdat), .o_req(req), .o_timeout(tmo));

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task wr(input logic [7:0] idx, input logic [31:0] d); i_cpu_bus_model.xfer(1'b1, idx, 4'h1, d, q); endtask
	task rd(input logic [7:0] idx); i_cpu_bus_model.xfer(1'b0, idx, 4'h1, 32'h0, q); endtask
	task word(input logic [15:0] a, input logic [3:0] s);
		i_cpu_bus_model.xfer(1'b1, IDX_ARRAY_ADDR, s, {a, 16'h5AA5}, q);
	endtask
	task run(input logic [7:0] c, input logic [15:0] a);
		word(a, 4'h3);
		wr(IDX_COMMAND, {24'h0, c});
		wr(IDX_STATUS, 32'h80);
	endtask
	task st(input logic [7:0] m, input logic [7:0] e); rd(IDX_STATUS); `CHK(q[7:0] & m, e) endtask
	task tick; @(posedge i_clk); #1; endtask
	// Bounded wait for hold and busy to drop
	task wait_idle;
		for (n = 0; n < 200 && (hold | busy) !== 1'b0; n++) @(posedge i_clk);
		if ((hold | busy) !== 1'b0) begin n_errors++; report_and_stop(); end
	endtask
	task do_reset;
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		tick; `CHK(busy, 1'b0)
		repeat (5) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		tick; `CHK(hold, 1'b1)
		wait_idle;
	endtask
	task report_and_stop;
		if (tmo === 1'b1) n_errors++;
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	always @(posedge tmo) report_and_stop();

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		i_clk = 1'b0; i_sys_rst = 1'b1; nv_prot = 8'hFF; nv_sec = 8'h02; n_errors = 0; checks = 0;
		do_reset;
		rd(IDX_PROTECT); `CHK(q[7:0], 8'hFF)
		rd(IDX_SECURITY); `CHK(q[7:0], 8'h02)
		st(8'hFF, 8'hC0);
		word(16'h0100, 4'h3); st(8'hF0, 8'hD0);
		wr(IDX_STATUS, 32'h10); st(8'hFF, 8'hC0);
		wr(IDX_STATUS, 32'h42); st(8'hFF, 8'hC0);
		wr(IDX_STATUS, 32'h0); st(8'hFF, 8'hC0);
		rd(8'h30); `CHK(q, 32'h0)
		wr(IDX_CLKDIV, 32'hA);
		// Each broken sequence must flag an error and lock launches
		for (i = 0; i < 8; i++) begin
			case (i)
				0: word(16'h0101, 4'h3);
				1: word(16'h0100, 4'h1);
				2: begin word(16'h0100, 4'h3); word(16'h0102, 4'h3); end
				3: begin word(16'h0100, 4'h3); wr(IDX_CONFIG, 32'h0); end
				4: begin word(16'h0100, 4'h3); wr(IDX_COMMAND, 32'h20); wr(IDX_COMMAND, 32'h20); end
				5: begin word(16'h0100, 4'h3); wr(IDX_COMMAND, 32'h77); end
				6: begin word(16'h0100, 4'h3); wr(IDX_COMMAND, 32'h20); wr(IDX_CONFIG, 32'h0); end
				default: begin word(16'h0100, 4'h3); wr(IDX_STATUS, 32'h0); end
			endcase
			st(8'h30, 8'h10);
			run(CMD_PROGRAM, 16'h0100); tick; `CHK(busy, 1'b0)
			wr(IDX_STATUS, 32'h10); st(8'hF0, 8'hC0);
		end
		wr(IDX_CONFIG, 32'hC0);
		for (i = 0; i < 4; i++) begin
			tick; `CHK(irq_be, 1'b1)
			run(cmds[i], 16'h0100); tick; `CHK(busy, 1'b1)
			st(8'hF0, 8'h00);
			rd(IDX_ARRAY_ADDR); `CHK(q, 32'h0)
			`CHK(irq_cc, 1'b0)
			if (i == 2) begin word(16'h0100, 4'h3); st(8'h30, 8'h10); end
			wait_idle; repeat (2) tick;
			`CHK({irq_be, irq_cc}, 2'h3)
			st(8'hE4, (cmds[i] == CMD_BLANK) ? 8'hC4 : 8'hC0);
			wr(IDX_STATUS, 32'h10);
		end
		run(CMD_PROGRAM, 16'h0100); wr(IDX_MODE, 32'h2); tick;
		`CHK(busy, 1'b0)
		st(8'h30, 8'h10);
		wr(IDX_MODE, 32'h0); wr(IDX_STATUS, 32'h10);
		wr(IDX_MODE, 32'h1); wr(IDX_STATUS, 32'h2); st(8'h03, 8'h03);
		wr(IDX_MODE, 32'h0); st(8'h03, 8'h00);
		wr(IDX_MODE, 32'h1); wr(IDX_STATUS, 32'h0); st(8'h03, 8'h01);
		wr(IDX_MODE, 32'h0);
		wr(IDX_PROTECT, 32'h7E); rd(IDX_PROTECT); `CHK(q[7:0], 8'h7E)
		run(CMD_PROGRAM, 16'h8000); st(8'h20, 8'h20);
		run(CMD_PROGRAM, 16'h0100); tick; `CHK(busy, 1'b0)
		wr(IDX_STATUS, 32'h20);
		run(CMD_MASS, 16'h0100); st(8'h20, 8'h20);
		tick; `CHK(busy, 1'b0)
		wr(IDX_STATUS, 32'h20);
		for (i = 0; i < 3; i++) begin
			wr(IDX_PROTECT, {24'h0, pw[i]}); rd(IDX_PROTECT); `CHK(q[2:0], pe[i])
		end
		@(posedge i_clk);
		nv_sec <= 8'h00;
		run(CMD_PROGRAM, 16'h0100); tick; `CHK(busy, 1'b1)
		do_reset;
		st(8'hFF, 8'hC0);
		wr(IDX_CLKDIV, 32'hA); wr(IDX_MODE, 32'h4);
		run(CMD_PROGRAM, 16'h0100); st(8'h30, 8'h10);
		wr(IDX_STATUS, 32'h10);
		run(CMD_MASS, 16'h0100); tick; `CHK(busy, 1'b1)
		wait_idle;
		report_and_stop();
	end
endmodule // tb_flash_command_controller
